// file: csm_defines.vh
`ifndef CSM_DEFINES_VH
`define CSM_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSM_ADDR_CTRL 8'h00
`define CSM_ADDR_TIMER_PRE 8'h04
`define CSM_ADDR_TIMER_RUN 8'h08
`define CSM_ADDR_STATUS 8'h0c

// ----------------------------------------
// control field positions and reset values
// ----------------------------------------
`define CSM_CTRL_HF_SRC_LSB 0
`define CSM_CTRL_XTAL_32M_BIT 2
`define CSM_CTRL_LF_SRC_LSB 4
`define CSM_CTRL_KEEP_HF_BIT 8
`define CSM_CTRL_KEEP_LF_BIT 9
`define CSM_CTRL_RESET 32'h0000_0020

// ----------------------------------------
// source encodings
// ----------------------------------------
`define CSM_HF_SRC_XTAL 2'h0
`define CSM_HF_SRC_EXT 2'h1
`define CSM_HF_SRC_RC 2'h2
`define CSM_LF_SRC_XTAL 2'h0
`define CSM_LF_SRC_EXT 2'h1
`define CSM_LF_SRC_RC 2'h2
`define CSM_LF_SRC_SYNTH 2'h3

// ----------------------------------------
// status field positions
// ----------------------------------------
`define CSM_ST_HF_RUN_BIT 0
`define CSM_ST_LF_RUN_BIT 1
`define CSM_ST_HF_1M_BIT 2
`define CSM_ST_RC_HF_BIT 3
`define CSM_ST_XTAL_HF_BIT 4
`define CSM_ST_RC_LF_BIT 5
`define CSM_ST_XTAL_LF_BIT 6
`define CSM_ST_SYNTH_BIT 7

// ----------------------------------------
// timer prescaler
// ----------------------------------------
`define CSM_PRE_WIDTH 4
// 16 MHz divided by 2^4 is 1 MHz: this setting and above ask for 1 MHz mode
`define CSM_PRE_1M 4'h4

`endif

// file: csm_gate.v
`timescale 1ns/1ps
`default_nettype none
module csm_gate #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // requests
    input wire sys_on,
    input wire [WIDTH-1:0] req,
    // branch enables
    output reg [WIDTH-1:0] gate_q
);

// ----------------------------------------
// per-branch gate
// ----------------------------------------
// registered enables rather than gated clocks: the cell-level gate sits downstream
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_br
        always @(posedge mclk or posedge rst) begin
            if (rst) begin
                gate_q[i] <= 1'b0;
            end else begin
                gate_q[i] <= sys_on & req[i]; // [R14]
            end
        end
    end
endgenerate

endmodule
`default_nettype wire

// file: csm_timer_pre.v
`timescale 1ns/1ps
`default_nettype none
`include "csm_defines.vh"
module csm_timer_pre (
    // clock and reset
    input wire mclk,
    input wire rst,
    // control
    input wire run,
    input wire [`CSM_PRE_WIDTH-1:0] pre,
    input wire hf_tick,
    // outputs
    output reg tick_q,
    output reg req_1m_q
);

// ----------------------------------------
// divider
// ----------------------------------------
reg [14:0] cnt_q;
wire [15:0] limit;

assign limit = 16'h0001 << pre;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        cnt_q <= 15'h0000;
        tick_q <= 1'b0;
        req_1m_q <= 1'b0;
    end else begin
        req_1m_q <= run & (pre >= `CSM_PRE_1M); // [R11]
        tick_q <= 1'b0;
        if (!run) begin
            cnt_q <= 15'h0000;
        end else if (hf_tick) begin
            if ({1'b0, cnt_q} == limit - 16'h0001) begin // [R10]
                cnt_q <= 15'h0000;
                tick_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 15'h0001;
            end
        end
    end
end

endmodule
`default_nettype wire

// file: csm_clock_mgr.v
// Summary of operation
// [R1] a module request with its oscillator idle starts the domain's rc oscillator
// [R2] rc oscillator idles automatically once the last requesting module goes idle
// [R3] software keep bit holds the selected oscillator running without requests
// [R4] no oscillator or clock branch is enabled while the system is off
// [R5] high clock comes from crystal, external reference or rc oscillator
// [R6] a 32 MHz crystal is divided by two so the system sees 16 MHz
// [R7] low clock comes from crystal, external reference, rc, or synthesis
// [R8] synthesized low clock keeps a high clock source running while used
// [R9] radio use needs the crystal selected and started by software first
// [R10] timer counts the high clock divided by two to the prescaler
// [R11] timers at or below 1 MHz count rate request 1 MHz mode
// [R12] only 1 MHz timer requests active switches the high clock to 1 MHz mode; the code also needs keep_hf clear
// [R13] level requests plus keep bits decide running; running status reported back
// [R14] clock branches of idle modules are gated off
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "csm_defines.vh"
module csm_clock_mgr #(
    parameter NUM_HF = 4,
    parameter NUM_LF = 2,
    parameter NUM_TMR = 3
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // system state and module requests
    input wire sys_on,
    input wire [NUM_HF-1:0] mod_hf_req,
    input wire [NUM_LF-1:0] mod_lf_req,
    input wire hf_tick,
    // oscillator readiness
    input wire xtal_hf_ready,
    input wire rc_hf_ready,
    input wire xtal_lf_ready,
    input wire rc_lf_ready,
    // oscillator controls
    output reg xtal_hf_en_q,
    output reg rc_hf_en_q,
    output reg xtal_lf_en_q,
    output reg rc_lf_en_q,
    output reg lf_synth_en_q,
    // clock routing
    output reg [1:0] high_freq_clock_sel_q,
    output reg high_freq_clock_div2_q,
    output reg high_freq_clock_1m_q,
    output reg [1:0] low_freq_clock_sel_q,
    output reg high_freq_clock_running_q,
    output reg low_freq_clock_running_q,
    // branch enables and timer ticks
    output wire [NUM_HF-1:0] hf_gate_q,
    output wire [NUM_LF-1:0] lf_gate_q,
    output wire [NUM_TMR-1:0] tmr_gate_q,
    output wire [NUM_TMR-1:0] tmr_tick_q
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [31:0] ctrl_q;
reg [4*NUM_TMR-1:0] tmr_pre_q;
reg [NUM_TMR-1:0] tmr_run_q;
wire [NUM_TMR-1:0] tmr_1m;

wire [1:0] hf_src;
wire [1:0] lf_src;
wire xtal_32m;
wire keep_hf;
wire keep_lf;

assign hf_src = ctrl_q[`CSM_CTRL_HF_SRC_LSB+1:`CSM_CTRL_HF_SRC_LSB];
assign lf_src = ctrl_q[`CSM_CTRL_LF_SRC_LSB+1:`CSM_CTRL_LF_SRC_LSB];
assign xtal_32m = ctrl_q[`CSM_CTRL_XTAL_32M_BIT];
assign keep_hf = ctrl_q[`CSM_CTRL_KEEP_HF_BIT];
assign keep_lf = ctrl_q[`CSM_CTRL_KEEP_LF_BIT];

function sel_hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
        sel_hit = (addr == offs);
    end
endfunction

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        ctrl_q <= `CSM_CTRL_RESET;
        tmr_pre_q <= {(4*NUM_TMR){1'b0}};
        tmr_run_q <= {NUM_TMR{1'b0}};
    end else if (reg_wr) begin
        if (sel_hit(reg_addr, `CSM_ADDR_CTRL)) begin
            // unused bits kept at zero so they read back as zero
            ctrl_q <= reg_wdata & 32'h0000_0337; // [R3]
        end
        if (sel_hit(reg_addr, `CSM_ADDR_TIMER_PRE)) begin
            tmr_pre_q <= reg_wdata[4*NUM_TMR-1:0];
        end
        if (sel_hit(reg_addr, `CSM_ADDR_TIMER_RUN)) begin
            tmr_run_q <= reg_wdata[NUM_TMR-1:0];
        end
    end
end

// ----------------------------------------
// demand
// ----------------------------------------
wire lf_demand;
wire lf_synth_use;
wire tmr_full;
wire full_req;
wire hf_demand;

assign lf_demand = sys_on & (|mod_lf_req | keep_lf); // [R13]
assign lf_synth_use = lf_demand & (lf_src == `CSM_LF_SRC_SYNTH); // [R7]
// a timer that runs but has not yet asked for 1 MHz counts as full rate
assign tmr_full = |(tmr_run_q & ~tmr_1m);
assign full_req = |mod_hf_req | tmr_full | lf_synth_use; // [R12]
// synthesis keeps the high domain alive for as long as it is in use
assign hf_demand = sys_on & (full_req | |tmr_run_q | keep_hf); // [R8]

// ----------------------------------------
// high-frequency source control
// ----------------------------------------
wire xtal_hf_on;
wire xtal_hf_live;
wire ext_hf_live;
wire rc_hf_on;

// crystal starts only under software keep; radio users must set it up first
assign xtal_hf_on = sys_on & keep_hf & (hf_src == `CSM_HF_SRC_XTAL); // [R9]
assign xtal_hf_live = xtal_hf_on & xtal_hf_ready;
assign ext_hf_live = hf_src == `CSM_HF_SRC_EXT;
// rc fills in whenever there is demand and the chosen source is not up
assign rc_hf_on = hf_demand & ~xtal_hf_live & ~ext_hf_live; // [R1]

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        xtal_hf_en_q <= 1'b0;
        rc_hf_en_q <= 1'b0;
        high_freq_clock_sel_q <= `CSM_HF_SRC_RC;
        high_freq_clock_div2_q <= 1'b0;
        high_freq_clock_1m_q <= 1'b0;
        high_freq_clock_running_q <= 1'b0;
    end else begin
        xtal_hf_en_q <= xtal_hf_on; // [R4]
        rc_hf_en_q <= rc_hf_on; // [R2]
        if (xtal_hf_live) begin
            high_freq_clock_sel_q <= `CSM_HF_SRC_XTAL; // [R5]
        end else if (ext_hf_live) begin
            high_freq_clock_sel_q <= `CSM_HF_SRC_EXT;
        end else begin
            high_freq_clock_sel_q <= `CSM_HF_SRC_RC;
        end
        high_freq_clock_div2_q <= xtal_hf_live & xtal_32m; // [R6]
        high_freq_clock_1m_q <= hf_demand & |tmr_1m & ~full_req & ~keep_hf; // [R12]
        high_freq_clock_running_q <= hf_demand &
            (xtal_hf_live | ext_hf_live | rc_hf_ready); // [R13]
    end
end

// ----------------------------------------
// low-frequency source control
// ----------------------------------------
wire xtal_lf_on;
wire xtal_lf_live;
wire ext_lf_live;
wire rc_lf_on;
wire synth_live;

assign xtal_lf_on = sys_on & keep_lf & (lf_src == `CSM_LF_SRC_XTAL); // [R3]
assign xtal_lf_live = xtal_lf_on & xtal_lf_ready;
assign ext_lf_live = lf_src == `CSM_LF_SRC_EXT;
assign rc_lf_on = lf_demand & ~lf_synth_use & ~xtal_lf_live & ~ext_lf_live; // [R1]
assign synth_live = lf_synth_use & high_freq_clock_running_q;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        xtal_lf_en_q <= 1'b0;
        rc_lf_en_q <= 1'b0;
        lf_synth_en_q <= 1'b0;
        low_freq_clock_sel_q <= `CSM_LF_SRC_RC;
        low_freq_clock_running_q <= 1'b0;
    end else begin
        xtal_lf_en_q <= xtal_lf_on; // [R4]
        rc_lf_en_q <= rc_lf_on; // [R2]
        lf_synth_en_q <= lf_synth_use; // [R8]
        if (lf_synth_use) begin
            low_freq_clock_sel_q <= `CSM_LF_SRC_SYNTH; // [R7]
        end else if (xtal_lf_live) begin
            low_freq_clock_sel_q <= `CSM_LF_SRC_XTAL;
        end else if (ext_lf_live) begin
            low_freq_clock_sel_q <= `CSM_LF_SRC_EXT;
        end else begin
            low_freq_clock_sel_q <= `CSM_LF_SRC_RC;
        end
        low_freq_clock_running_q <= lf_demand &
            (synth_live | xtal_lf_live | ext_lf_live | (~lf_synth_use & rc_lf_ready)); // [R13]
    end
end

// ----------------------------------------
// timers
// ----------------------------------------
genvar t;
generate
    for (t = 0; t < NUM_TMR; t = t + 1) begin : g_tmr
        csm_timer_pre u_pre (
            .mclk(mclk),
            .rst(rst),
            .run(tmr_run_q[t] & sys_on),
            .pre(tmr_pre_q[4*t+3:4*t]),
            .hf_tick(hf_tick & high_freq_clock_running_q), // [R10]
            .tick_q(tmr_tick_q[t]),
            .req_1m_q(tmr_1m[t]) // [R11]
        );
    end
endgenerate

// ----------------------------------------
// clock branch gates
// ----------------------------------------
csm_gate #(
    .WIDTH(NUM_HF)
) u_hf_gate (
    .mclk(mclk),
    .rst(rst),
    .sys_on(sys_on),
    .req(mod_hf_req),
    .gate_q(hf_gate_q)
);

csm_gate #(
    .WIDTH(NUM_LF)
) u_lf_gate (
    .mclk(mclk),
    .rst(rst),
    .sys_on(sys_on),
    .req(mod_lf_req),
    .gate_q(lf_gate_q)
);

csm_gate #(
    .WIDTH(NUM_TMR)
) u_tmr_gate (
    .mclk(mclk),
    .rst(rst),
    .sys_on(sys_on),
    .req(tmr_run_q),
    .gate_q(tmr_gate_q)
);

// ----------------------------------------
// read path
// ----------------------------------------
reg [31:0] rd_mux;

always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
        `CSM_ADDR_CTRL: begin
            rd_mux = ctrl_q;
        end
        `CSM_ADDR_TIMER_PRE: begin
            rd_mux[4*NUM_TMR-1:0] = tmr_pre_q;
        end
        `CSM_ADDR_TIMER_RUN: begin
            rd_mux[NUM_TMR-1:0] = tmr_run_q;
        end
        `CSM_ADDR_STATUS: begin
            rd_mux[`CSM_ST_HF_RUN_BIT] = high_freq_clock_running_q; // [R13]
            rd_mux[`CSM_ST_LF_RUN_BIT] = low_freq_clock_running_q;
            rd_mux[`CSM_ST_HF_1M_BIT] = high_freq_clock_1m_q;
            rd_mux[`CSM_ST_RC_HF_BIT] = rc_hf_en_q;
            rd_mux[`CSM_ST_XTAL_HF_BIT] = xtal_hf_en_q;
            rd_mux[`CSM_ST_RC_LF_BIT] = rc_lf_en_q;
            rd_mux[`CSM_ST_XTAL_LF_BIT] = xtal_lf_en_q;
            rd_mux[`CSM_ST_SYNTH_BIT] = lf_synth_en_q;
        end
        default: begin
            rd_mux = 32'h0000_0000;
        end
    endcase
end

// data stand only in the cycle after the strobe, zero otherwise
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
        reg_rdata_q <= rd_mux;
    end else begin
        reg_rdata_q <= 32'h0000_0000;
    end
end

endmodule
`default_nettype wire

// file: csm_clock_mgr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module csm_clock_mgr_sva #(
    parameter NUM_HF = 4,
    parameter NUM_LF = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // inputs
    input wire logic sys_on,
    input wire logic [NUM_HF-1:0] mod_hf_req,
    input wire logic [NUM_LF-1:0] mod_lf_req,
    input wire logic xtal_hf_ready,
    input wire logic rc_hf_ready,
    // outputs
    input wire logic xtal_hf_en_q,
    input wire logic rc_hf_en_q,
    input wire logic xtal_lf_en_q,
    input wire logic rc_lf_en_q,
    input wire logic lf_synth_en_q,
    input wire logic [1:0] high_freq_clock_sel_q,
    input wire logic high_freq_clock_1m_q,
    input wire logic [1:0] low_freq_clock_sel_q,
    input wire logic high_freq_clock_running_q,
    input wire logic low_freq_clock_running_q,
    input wire logic [NUM_HF-1:0] hf_gate_q,
    input wire logic [NUM_LF-1:0] lf_gate_q
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    // source select must be settled, else the demand is judged on a stale choice
    sequence s_hf_rc_demand;
        sys_on && mod_hf_req != 0 && high_freq_clock_sel_q == 2'h2 && $stable(high_freq_clock_sel_q);
    endsequence
    a_hf_rc_start: assert property (s_hf_rc_demand |=> rc_hf_en_q)
        else $error("rc high oscillator not started on demand");
    // demand seen on two edges with rc still routed, so a fresh source change has landed
    sequence s_lf_rc_demand;
        sys_on && mod_lf_req != 0 && low_freq_clock_sel_q == 2'h2
            ##1 sys_on && mod_lf_req != 0 && low_freq_clock_sel_q == 2'h2;
    endsequence
    a_lf_rc_start: assert property (s_lf_rc_demand |=> rc_lf_en_q)
        else $error("rc low oscillator not started on demand");
    a_off_quiet: assert property (!sys_on |=> !(xtal_hf_en_q || rc_hf_en_q || xtal_lf_en_q || rc_lf_en_q
        || lf_synth_en_q || high_freq_clock_running_q || low_freq_clock_running_q))
        else $error("oscillator or clock active while system off");
    a_hf_gate_follow: assert property (1'b1 |=> hf_gate_q == ($past(mod_hf_req) & {NUM_HF{$past(sys_on)}}))
        else $error("high clock branch gate wrong");
    a_lf_gate_follow: assert property (1'b1 |=> lf_gate_q == ($past(mod_lf_req) & {NUM_LF{$past(sys_on)}}))
        else $error("low clock branch gate wrong");
    a_hf_run_cause: assert property ($rose(high_freq_clock_running_q) |-> $past(sys_on)
        && $past(rc_hf_ready || xtal_hf_ready || high_freq_clock_sel_q == 2'h1))
        else $error("high clock running without a ready source");
    a_synth_keeps_hf: assert property (lf_synth_en_q |-> rc_hf_en_q || xtal_hf_en_q || high_freq_clock_sel_q == 2'h1)
        else $error("synthesized low clock without high source");
    a_full_rate: assert property (mod_hf_req != 0 |=> !high_freq_clock_1m_q)
        else $error("reduced mode kept under full rate request");
endmodule
bind csm_clock_mgr csm_clock_mgr_sva #(.NUM_HF(NUM_HF), .NUM_LF(NUM_LF)) csm_clock_mgr_sva_inst (
    .mclk(mclk), .rst(rst), .sys_on(sys_on), .mod_hf_req(mod_hf_req), .mod_lf_req(mod_lf_req),
    .xtal_hf_ready(xtal_hf_ready), .rc_hf_ready(rc_hf_ready), .xtal_hf_en_q(xtal_hf_en_q),
    .rc_hf_en_q(rc_hf_en_q), .xtal_lf_en_q(xtal_lf_en_q), .rc_lf_en_q(rc_lf_en_q), .lf_synth_en_q(lf_synth_en_q),
    .high_freq_clock_sel_q(high_freq_clock_sel_q), .high_freq_clock_1m_q(high_freq_clock_1m_q),
    .low_freq_clock_sel_q(low_freq_clock_sel_q), .high_freq_clock_running_q(high_freq_clock_running_q),
    .low_freq_clock_running_q(low_freq_clock_running_q), .hf_gate_q(hf_gate_q), .lf_gate_q(lf_gate_q));
`default_nettype wire

// file: csm_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module csm_osc_model #(
    parameter START_XTAL = 12,
    parameter START_RC = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // order: xtal hf, xtal lf, rc hf, rc lf
    input wire logic [3:0] en,
    output logic [3:0] ready
);
    int cnt_q [4];
    // crystals are slow to settle, rc prompt; ready drops the moment enable goes
    always @(posedge mclk or posedge rst) begin
        for (int i = 0; i < 4; i++) begin
            if (rst || !en[i]) begin
                cnt_q[i] <= 0;
            end else if (cnt_q[i] < START_XTAL) begin
                cnt_q[i] <= cnt_q[i] + 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ready[i] = en[i] && cnt_q[i] >= (i < 2 ? START_XTAL : START_RC);
        end
    end
endmodule
`default_nettype wire

// file: csm_clock_mgr_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "csm_defines.vh"
module csm_clock_mgr_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sys_on = 0, hf_tick = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] mod_hf_req = 4'h0;
    logic [1:0] mod_lf_req = 2'h0;
    wire [31:0] reg_rdata_q;
    wire xtal_hf_en_q, rc_hf_en_q, xtal_lf_en_q, rc_lf_en_q, lf_synth_en_q, div2, hf_1m, hf_run, lf_run;
    wire xtal_hf_ready, rc_hf_ready, xtal_lf_ready, rc_lf_ready;
    wire [1:0] hsel, lsel, lf_gate_q;
    wire [3:0] hf_gate_q;
    wire [2:0] tmr_gate_q, tmr_tick_q;
    int seed = 34477, fail_count = 0, cmp_count = 0, n_hf = 0, n_tk = 0, h0, t0;
    csm_clock_mgr csm_clock_mgr_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sys_on(sys_on), .mod_hf_req(mod_hf_req),
        .mod_lf_req(mod_lf_req), .hf_tick(hf_tick), .xtal_hf_ready(xtal_hf_ready), .rc_hf_ready(rc_hf_ready),
        .xtal_lf_ready(xtal_lf_ready), .rc_lf_ready(rc_lf_ready), .xtal_hf_en_q(xtal_hf_en_q),
        .rc_hf_en_q(rc_hf_en_q), .xtal_lf_en_q(xtal_lf_en_q), .rc_lf_en_q(rc_lf_en_q),
        .lf_synth_en_q(lf_synth_en_q), .high_freq_clock_sel_q(hsel), .high_freq_clock_div2_q(div2),
        .high_freq_clock_1m_q(hf_1m), .low_freq_clock_sel_q(lsel), .high_freq_clock_running_q(hf_run),
        .low_freq_clock_running_q(lf_run), .hf_gate_q(hf_gate_q), .lf_gate_q(lf_gate_q),
        .tmr_gate_q(tmr_gate_q), .tmr_tick_q(tmr_tick_q));
    csm_osc_model csm_osc_model_inst (.mclk(mclk), .rst(rst),
        .en({rc_lf_en_q, rc_hf_en_q, xtal_lf_en_q, xtal_hf_en_q}),
        .ready({rc_lf_ready, rc_hf_ready, xtal_lf_ready, xtal_hf_ready}));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        n_hf += hf_tick;
        n_tk += tmr_tick_q[0];
    end
    function automatic logic [3:0] gate_of(input logic [3:0] r, input logic on);
        return r & {4{on}};
    endfunction
    function automatic logic near(input int a, input int b);
        return a >= b - 1 && a <= b + 1;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk);
            hf_tick <= 1'($random(seed));
        end
        // step off the edge so registered outputs are settled when compared
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    // read data stand only in the cycle after the strobe, so check right there
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 0;
        #1 chk(reg_rdata_q, e);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 0;
        rd(`CSM_ADDR_CTRL, `CSM_CTRL_RESET);
        rd(`CSM_ADDR_STATUS, 32'h0);
        rd(8'h10, 32'h0);
        chk(hsel, `CSM_HF_SRC_RC);
        chk(lsel, `CSM_LF_SRC_RC);
        $display("test reset done");
        repeat (60) begin
            @(posedge mclk);
            sys_on <= 1'($random(seed));
            mod_hf_req <= 4'($random(seed));
            mod_lf_req <= 2'($random(seed));
            @(posedge mclk);
            #1 chk(hf_gate_q, gate_of(mod_hf_req, sys_on));
            chk(lf_gate_q, gate_of({2'h0, mod_lf_req}, sys_on));
            chk(rc_hf_en_q, sys_on && mod_hf_req != 0);
            chk(rc_lf_en_q, sys_on && mod_lf_req != 0);
        end
        $display("test random demand done");
        sys_on <= 1;
        mod_hf_req <= 0;
        mod_lf_req <= 0;
        // crystal kept running with no demand, as radio use would need
        wr(`CSM_ADDR_CTRL, 32'h124);
        cyc(16);
        chk(xtal_hf_en_q, 1);
        chk(div2, 1);
        rd(`CSM_ADDR_STATUS, 32'h11);
        wr(`CSM_ADDR_CTRL, 32'h21);
        mod_hf_req <= 4'h2;
        cyc(3);
        chk(xtal_hf_en_q, 0);
        chk(rc_hf_en_q, 0);
        chk(div2, 0);
        mod_hf_req <= 0;
        wr(`CSM_ADDR_CTRL, 32'h32);
        mod_lf_req <= 2'h1;
        cyc(3);
        chk(lsel, `CSM_LF_SRC_SYNTH);
        chk({lf_synth_en_q, rc_hf_en_q}, 2'h3);
        mod_lf_req <= 0;
        // low crystal held by its keep bit with no low clock users
        wr(`CSM_ADDR_CTRL, 32'h200);
        cyc(16);
        chk(xtal_lf_en_q, 1);
        chk(lf_run, 1);
        wr(`CSM_ADDR_CTRL, `CSM_CTRL_RESET);
        $display("test sources done");
        wr(`CSM_ADDR_TIMER_PRE, 32'h3);
        wr(`CSM_ADDR_TIMER_RUN, 32'h1);
        h0 = n_hf;
        t0 = n_tk;
        cyc(400);
        chk(tmr_gate_q, 3'h1);
        chk(near(n_tk - t0, (n_hf - h0) >> 3), 1);
        chk(hf_1m, 0);
        wr(`CSM_ADDR_TIMER_PRE, {28'h0, `CSM_PRE_1M});
        cyc(4);
        chk(hf_1m, 1);
        mod_hf_req <= 4'h8;
        cyc(2);
        chk(hf_1m, 0);
        mod_hf_req <= 0;
        wr(`CSM_ADDR_TIMER_RUN, 32'h0);
        $display("test timer done");
        mod_hf_req <= 4'hf;
        sys_on <= 0;
        cyc(3);
        chk({hf_gate_q, rc_hf_en_q, hf_run}, 6'h0);
        $display("test system off done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
